// ==== logic/sdc_pkg.sv ====
// Package of shared constants for the synthesizer control link
package sdc_pkg;
	localparam int WORD_W = 24;
	localparam logic [1:0] SEL_FBDIV = 2'h0;
	localparam logic [1:0] SEL_REFMOD = 2'h1;
	localparam logic [1:0] SEL_CTRL = 2'h2;
	// Control word field positions
	localparam int CTL_RESYNC_LSB = 12;
	localparam int CTL_DOUBLER = 11;
	localparam int CTL_PUMP_LSB = 7;
	localparam int CTL_POLARITY = 6;
	localparam int CTL_PRECISION = 5;
	localparam int CTL_PDOWN = 4;
	localparam int CTL_TRISTATE = 3;
	localparam int CTL_CRESET = 2;
	// Feedback divider field positions
	localparam int FB_FRACTIONAL_NUMERATOR_LSB = 2;
	localparam int FB_INT_LSB = 14;
	localparam int FB_FASTLOCK = 23;
	// Reference divider field positions
	localparam int RM_VAL_LSB = 2;
	localparam int RM_R_LSB = 14;
	localparam int RM_MON_LSB = 20;
	localparam int RM_LOAD = 23;
	// Lock detect thresholds
	localparam logic [5:0] LOCK_RUN_LONG = 6'h28;
	localparam logic [5:0] LOCK_RUN_SHORT = 6'h18;
	localparam int PHASE_GOOD_NS = 15;
	localparam int PHASE_BAD_NS = 30;
	// Pump multiplier in fast lock and in normal operation
	localparam logic [4:0] PUMP_FAST = 5'h10;
	localparam logic [4:0] PUMP_NORMAL = 5'h01;
	// Host wishbone register offsets, serial clock half period and bit count start
	localparam logic [3:0] A_DATA = 4'h0;
	localparam logic [3:0] A_CMD = 4'h4;
	localparam logic [3:0] A_STAT = 4'h8;
	localparam logic [3:0] A_CLR = 4'hC;
	localparam logic [2:0] A_IEN_W = 3'h4;
	localparam logic [7:0] CLK_HALF = 8'h04;
	localparam logic [4:0] BIT_CNT_INIT = 5'h17;
endpackage : sdc_pkg

// ==== logic/sdc_link_if.sv ====
// Three-wire serial link between host and synthesizer
`timescale 1ns/1ns
interface sdc_link_if;
	logic sclk;
	logic sdata;
	logic le;
	logic lock;
	modport host (output sclk, output sdata, output le, input lock);
	modport dev (input sclk, input sdata, input le, output lock);
endinterface : sdc_link_if

// ==== logic/sdc_lock_det.sv ====
// Digital lock detector counted in comparator cycles
`timescale 1ns/1ns
module sdc_lock_det (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cmp_tick_i,
	input wire logic [7:0] err_ns_i,
	input wire logic long_run_i,
	input wire logic clear_i,
	output logic lock_o
);
	logic [5:0] run_r;
	logic [5:0] need;
	assign need = long_run_i ? sdc_pkg::LOCK_RUN_LONG
		: sdc_pkg::LOCK_RUN_SHORT;
	// Count good cycles, drop lock on large error
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			run_r <= 6'h00;
			lock_o <= 1'b0;
		end else if (cmp_tick_i) begin
			if (err_ns_i < 8'(sdc_pkg::PHASE_GOOD_NS)) begin
				if (run_r != need)
					run_r <= run_r + 6'h01;
				if (run_r + 6'h01 >= need)
					lock_o <= 1'b1;
			end else begin
				run_r <= 6'h00;
			end
			if (err_ns_i > 8'(sdc_pkg::PHASE_BAD_NS))
				lock_o <= 1'b0;
		end
	end
endmodule : sdc_lock_det

// ==== logic/sdc_device.sv ====
// Synthesizer end: serial register bank and lock detect
`timescale 1ns/1ns
module sdc_device (
	input wire logic clk_i,
	input wire logic rst_i,
	sdc_link_if.dev link,
	input wire logic cmp_tick_i,
	input wire logic [7:0] err_ns_i,
	output logic [15:0] ctrl_o,
	output logic [8:0] int_val_o,
	output logic [11:0] fractional_numerator_o,
	output logic [11:0] modulus_o,
	output logic [3:0] ref_div_o,
	output logic prescaler_o,
	output logic [2:0] monitor_output_select_o,
	output logic [4:0] pump_mult_o,
	output logic wide_band_o,
	output logic counters_hold_o,
	output logic pump_tristate_o,
	output logic lock_o
);
	logic [2:0] sclk_s;
	logic [2:0] sdata_s;
	logic [2:0] le_s;
	logic [23:0] shift_r;
	logic [23:0] fb_r;
	logic [23:0] rm_r;
	logic [11:0] mod_pend_r;
	logic [11:0] timer_r;
	logic [11:0] fl_cnt_r;
	logic fl_active_r;
	logic latch;
	logic fb_wr;
	logic pdown;
	logic lock_raw;
	logic cnt_reset;
	logic pump_off;
	logic fine_lock;

	// Pin synchronisers; stages 0 and 1 tame metastability,
	// stage 2 delays stage 1 for the edge detectors and is the data bit shifted in
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_s <= 3'h0;
			sdata_s <= 3'h0;
			le_s <= 3'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], link.sclk};
			sdata_s <= {sdata_s[1:0], link.sdata};
			le_s <= {le_s[1:0], link.le};
		end
	end

	// Latch strobe and divider-write decode
	assign latch = le_s[1] && !le_s[2];
	assign fb_wr = latch && shift_r[1:0] == sdc_pkg::SEL_FBDIV;

	// Control word bits that steer the synthesizer core
	assign pdown = ctrl_o[sdc_pkg::CTL_PDOWN];
	assign cnt_reset = ctrl_o[sdc_pkg::CTL_CRESET];
	assign pump_off = ctrl_o[sdc_pkg::CTL_TRISTATE];
	assign fine_lock = ctrl_o[sdc_pkg::CTL_PRECISION];

	// Shift in on rising clock, MSB first; runs in power-down
	always_ff @(posedge clk_i) begin
		if (rst_i)
			shift_r <= 24'h000000;
		else if (sclk_s[1] && !sclk_s[2])
			shift_r <= {shift_r[22:0], sdata_s[2]};
	end

	// Register latch on the rising edge of load enable
	// Only the selected register moves; select 11 is not held here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_o <= 16'h0000;
			fb_r <= 24'h000000;
			rm_r <= 24'h000000;
			mod_pend_r <= 12'h000;
			timer_r <= 12'h000;
		end else if (latch) begin
			unique case (shift_r[1:0])
				sdc_pkg::SEL_FBDIV: fb_r <= shift_r;
				sdc_pkg::SEL_REFMOD: begin
					rm_r <= shift_r;
					if (shift_r[sdc_pkg::RM_LOAD])
						timer_r <= shift_r[sdc_pkg::RM_VAL_LSB +: 12];
					else
						mod_pend_r <= shift_r[sdc_pkg::RM_VAL_LSB +: 12];
				end
				sdc_pkg::SEL_CTRL: ctrl_o <= shift_r[15:0];
				default: ;
			endcase
		end
	end

	// Double-buffered modulus moves on a divider write
	// Pending value waits so that the ratio changes in one step
	always_ff @(posedge clk_i) begin
		if (rst_i)
			modulus_o <= 12'h000;
		else if (fb_wr)
			modulus_o <= mod_pend_r;
	end

	// Feedback divider fields
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_val_o <= 9'h000;
			fractional_numerator_o <= 12'h000;
		end else begin
			int_val_o <= fb_r[sdc_pkg::FB_INT_LSB +: 9];
			fractional_numerator_o <= fb_r[sdc_pkg::FB_FRACTIONAL_NUMERATOR_LSB +: 12];
		end
	end

	// Reference divider fields; a timer load rewrites these too
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_div_o <= 4'h0;
			prescaler_o <= 1'b0;
			monitor_output_select_o <= 3'h0;
		end else begin
			ref_div_o <= rm_r[sdc_pkg::RM_R_LSB +: 4];
			prescaler_o <= rm_r[sdc_pkg::RM_R_LSB + 4];
			monitor_output_select_o <= rm_r[sdc_pkg::RM_MON_LSB +: 3];
		end
	end

	// Fast-lock timer counts comparator cycles after a divider write
	// A zero timer would wrap and run 4096 comparator cycles, so it leaves fast lock off
	always_ff @(posedge clk_i) begin
		if (rst_i || pdown) begin
			fl_active_r <= 1'b0;
			fl_cnt_r <= 12'h000;
		end else if (fb_wr) begin
			fl_active_r <= shift_r[sdc_pkg::FB_FASTLOCK] && timer_r != 12'h000;
			fl_cnt_r <= timer_r;
		end else if (fl_active_r && cmp_tick_i) begin
			fl_cnt_r <= fl_cnt_r - 12'h001;
			if (fl_cnt_r == 12'h001)
				fl_active_r <= 1'b0;
		end
	end

	// Pump current multiplier and loop bandwidth
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pump_mult_o <= sdc_pkg::PUMP_NORMAL;
			wide_band_o <= 1'b0;
		end else begin
			pump_mult_o <= fl_active_r ? sdc_pkg::PUMP_FAST
				: sdc_pkg::PUMP_NORMAL;
			wide_band_o <= fl_active_r;
		end
	end

	// Counter hold and pump three-state; power-down forces both
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			counters_hold_o <= 1'b1;
			pump_tristate_o <= 1'b1;
		end else begin
			counters_hold_o <= pdown || cnt_reset;
			pump_tristate_o <= pdown || pump_off;
		end
	end

	// Lock indication to the core and back over the link
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_o <= 1'b0;
			link.lock <= 1'b0;
		end else begin
			lock_o <= lock_raw;
			link.lock <= lock_raw;
		end
	end

	// Lock detector; a new channel or power-down restarts it
	sdc_lock_det u_lock (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cmp_tick_i(cmp_tick_i),
		.err_ns_i(err_ns_i),
		.long_run_i(fine_lock),
		.clear_i(pdown || fb_wr),
		.lock_o(lock_raw)
	);
endmodule : sdc_device

// ==== logic/sdc_host.sv ====
// Host end: wishbone registers driving the three-wire link
`timescale 1ns/1ns
module sdc_host (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	output logic irq_o,
	sdc_link_if.host link
);
	typedef enum logic [1:0] {
		SDC_IDLE = 2'b00, SDC_LOW = 2'b01, SDC_HIGH = 2'b10, SDC_LE = 2'b11
	} sdc_state_e;
	sdc_state_e st_r;
	logic [23:0] word_r;
	logic [4:0] bit_r;
	logic [7:0] div_r;
	logic [1:0] stat_r;
	logic [1:0] ien_r;
	logic [2:0] lock_s;
	logic req;
	logic done;
	assign req = cyc_i && stb_i && !ack_o;
	assign done = st_r == SDC_LE && div_r == sdc_pkg::CLK_HALF;
	// Wishbone answer one cycle after request; data word goes to 0x0
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			word_r <= 24'h000000;
			ien_r <= 2'h0;
		end else begin
			ack_o <= req;
			dat_o <= 32'h00000000;
			if (req && we_i && adr_i == sdc_pkg::A_DATA && st_r == SDC_IDLE)
				word_r <= dat_i[23:0];
			if (req && we_i && adr_i[2:0] == sdc_pkg::A_IEN_W && adr_i[3])
				ien_r <= ien_r;
			if (req && we_i && adr_i == sdc_pkg::A_CMD && dat_i[31])
				ien_r <= dat_i[1:0];
			if (req && !we_i && adr_i == sdc_pkg::A_STAT)
				dat_o <= {28'h0000000, st_r != SDC_IDLE, lock_s[2], stat_r};
			if (req && !we_i && adr_i == sdc_pkg::A_CMD)
				dat_o <= {30'h00000000, ien_r};
		end
	end
	// Shift engine: start command, clock divider, load enable pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= SDC_IDLE;
			bit_r <= 5'h00;
			div_r <= 8'h00;
			link.sclk <= 1'b0;
			link.sdata <= 1'b0;
			link.le <= 1'b0;
		end else begin
			div_r <= (div_r == sdc_pkg::CLK_HALF) ? 8'h00 : div_r + 8'h01;
			unique case (st_r)
				SDC_IDLE: begin
					div_r <= 8'h00;
					if (req && we_i && adr_i == sdc_pkg::A_CMD && dat_i[0]) begin
						st_r <= SDC_LOW;
						bit_r <= sdc_pkg::BIT_CNT_INIT;
						link.sdata <= word_r[23];
					end
				end
				SDC_LOW: if (div_r == sdc_pkg::CLK_HALF) begin
					link.sclk <= 1'b1;
					st_r <= SDC_HIGH;
				end
				SDC_HIGH: if (div_r == sdc_pkg::CLK_HALF) begin
					link.sclk <= 1'b0;
					if (bit_r == 5'h00) begin
						st_r <= SDC_LE;
						link.le <= 1'b1;
					end else begin
						bit_r <= bit_r - 5'h01;
						link.sdata <= word_r[bit_r - 5'h01];
						st_r <= SDC_LOW;
					end
				end
				SDC_LE: if (done) begin
					link.le <= 1'b0;
					st_r <= SDC_IDLE;
				end
			endcase
		end
	end
	// Lock synchroniser and sticky status: bit0 sent, bit1 lock lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_s <= 3'h0;
			stat_r <= 2'h0;
			irq_o <= 1'b0;
		end else begin
			lock_s <= {lock_s[1:0], link.lock};
			if (req && we_i && adr_i == sdc_pkg::A_CLR)
				stat_r <= (stat_r & ~dat_i[1:0]) | {lock_s[2] & ~lock_s[1], done};
			else
				stat_r <= stat_r | {lock_s[2] & ~lock_s[1], done};
			irq_o <= |(stat_r & ien_r);
		end
	end
endmodule : sdc_host

// ==== verification/sdc_link_properties.sv ====
// Timing checks on the three-wire synthesizer link
`timescale 1ns/1ns
module sdc_link_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic le,
	input wire logic lock
);
	logic [5:0] bits_r;
	logic [23:0] word_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Clock rises since the last latch
	always_ff @(posedge clk_i) begin
		if (rst_i || le)
			bits_r <= 6'h00;
		else if ($rose(sclk))
			bits_r <= bits_r + 6'h01;
	end
	// Word as seen on the wire, for select decode
	always_ff @(posedge clk_i) begin
		if (rst_i)
			word_r <= 24'h000000;
		else if ($rose(sclk))
			word_r <= {word_r[22:0], sdata};
	end
	AST_HIGH: assert property ($rose(sclk) |-> sclk[*5] ##1 !sclk)
		else $error("sclk high time wrong");
	AST_LOW: assert property ($fell(sclk) && bits_r != 6'h18 |->
		!sclk[*5] ##1 sclk)
		else $error("sclk low time wrong");
	AST_STABLE: assert property (sclk && $past(sclk) |-> $stable(sdata))
		else $error("data moved while sclk high");
	AST_NOCLK: assert property (le |-> !sclk)
		else $error("sclk high during latch");
	AST_WHOLE: assert property ($rose(le) |-> bits_r == 6'h18)
		else $error("latch without 24 bits");
	AST_GAP: assert property ($rose(le) |->
		$fell(sclk) && $past(sclk, 5))
		else $error("latch not at end of last clock pulse");
	AST_LEEND: assert property ($rose(le) |-> ##[1:20] !le)
		else $error("latch never released");
	AST_AFTER: assert property ($rose(sclk) |-> !$past(le))
		else $error("clock right after latch");
	AST_NEWCHAN: assert property ($rose(le) && word_r[1:0] == 2'h0 |->
		##[1:8] !lock)
		else $error("lock kept after new channel");
endmodule : sdc_link_properties

// ==== verification/testbench.sv ====
// Self-checking bench joining host and synthesizer ends
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
	logic clk_i, rst_i, we, cyc, stb, ack, irq, cmp, lock_o, wb_o, tri_o, hold_o;
	logic [3:0] adr, rdv;
	logic [31:0] wd, rd, q, v;
	logic [7:0] err, ge;
	logic [15:0] c, ctl;
	logic [11:0] m, f, fractional_numerator, mdl;
	logic [8:0] i, iv;
	logic [4:0] pump;
	logic [2:0] mon;
	logic pre;
	int seed = 38224, bad_count = 0, num_checks = 0, am = 0, n, p;
	sdc_link_if link();
	sdc_host u_sdc_host (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wd),
		.dat_o(rd), .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb),
		.ack_o(ack), .irq_o(irq), .link(link));
	sdc_device u_sdc_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.cmp_tick_i(cmp), .err_ns_i(err), .ctrl_o(ctl), .int_val_o(iv),
		.fractional_numerator_o(fractional_numerator), .modulus_o(mdl), .ref_div_o(rdv), .prescaler_o(pre),
		.monitor_output_select_o(mon), .pump_mult_o(pump), .wide_band_o(wb_o),
		.counters_hold_o(hold_o), .pump_tristate_o(tri_o), .lock_o(lock_o));
	sdc_link_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
		.sclk(link.sclk), .sdata(link.sdata), .le(link.le), .lock(link.lock));
	// Free-running clock
	always #50 clk_i = ~clk_i;
	// Verdict and end of run
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	// Classic single bus cycle, answer taken at the ack edge
	task wb(input logic [3:0] a, input logic [31:0] d, input logic w);
		n = 0;
		@(posedge clk_i);
		adr <= a;
		wd <= d;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(negedge clk_i); while (ack !== 1'b1 && ++n < 20);
		@(posedge clk_i);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			wrap_up();
		end
		@(negedge clk_i);
	endtask : wb
	// Send one serial word and wait for it to land
	task send(input logic [23:0] w);
		wb(sdc_pkg::A_DATA, {8'h00, w}, 1'b1);
		wb(sdc_pkg::A_CMD, 32'h00000001, 1'b1);
		p = 0;
		do wb(sdc_pkg::A_STAT, 32'h0, 1'b0); while (!q[0] && ++p < 200);
		if (p >= 200) begin
			bad_count++;
			wrap_up();
		end
		wb(sdc_pkg::A_CLR, 32'h00000001, 1'b1);
		repeat (6) @(negedge clk_i);
	endtask : send
	// Comparator cycles with a given phase error
	task tk(input logic [7:0] e, input int k);
		repeat (k) begin
			@(posedge clk_i);
			cmp <= 1'b1;
			err <= e;
			@(posedge clk_i);
			cmp <= 1'b0;
			@(posedge clk_i);
		end
		@(negedge clk_i);
	endtask : tk
	// Main sequence
	initial begin
		clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; wd = 0;
		cmp = 0; err = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		v = $random(seed);
		c = {v[15:5], 1'b0, v[3:2], 2'h2}; // Power-down is tested last
		send({8'h00, c});
		`CHK(ctl, c)
		`CHK(hold_o, c[2] | c[4])
		`CHK(tri_o, c[3] | c[4])
		$display("control done");
		v = $random(seed);
		m = {1'b1, v[10:0]};
		send({1'b0, v[14:12], 1'b0, v[15], v[19:16], m, 2'h1});
		`CHK(rdv, v[19:16])
		`CHK(mon, v[14:12])
		`CHK(pre, v[15])
		`CHK(mdl, am[11:0])
		f = {1'b0, v[30:20]};
		i = v[8:0];
		send({1'b0, i, f, 2'h0});
		am = m;
		`CHK(iv, i)
		`CHK(fractional_numerator, f)
		`CHK(mdl, am[11:0])
		$display("divider done");
		send(24'h800019);
		`CHK(mdl, am[11:0])
		send({1'b1, i, f, 2'h0});
		`CHK(pump, sdc_pkg::PUMP_FAST)
		`CHK(wb_o, 1'b1)
		tk(8'h01, 5);
		`CHK(wb_o, 1'b1)
		tk(8'h01, 1);
		`CHK(wb_o, 1'b0)
		`CHK(pump, sdc_pkg::PUMP_NORMAL)
		$display("fast lock done");
		wb(sdc_pkg::A_CMD, 32'h80000002, 1'b1);
		for (int k = 0; k < 2; k++) begin
			send({8'h00, 10'h000, k[0], 3'h0, 2'h2});
			send({1'b0, i, f, 2'h0});
			v = $random(seed);
			ge = 8'(v[3:0] % 15);
			tk(ge, k ? 39 : 23);
			`CHK(lock_o, 1'b0)
			tk(ge, 1);
			`CHK(lock_o, 1'b1)
			tk(8'h16, 2);
			`CHK(lock_o, 1'b1)
			tk(8'h1F, 1);
			`CHK(lock_o, 1'b0)
			repeat (6) @(negedge clk_i);
			`CHK(irq, 1'b1)
			wb(sdc_pkg::A_CLR, 32'h00000002, 1'b1);
			`CHK(irq, 1'b0)
		end
		$display("lock done");
		send(24'h000012);
		`CHK(hold_o, 1'b1)
		`CHK(tri_o, 1'b1)
		`CHK(iv, i)
		i = ~i;
		send({1'b0, i, f, 2'h0});
		`CHK(iv, i)
		wb(4'h2, 32'h0, 1'b0);
		`CHK(q, 32'h0)
		wb(sdc_pkg::A_CMD, 32'h0, 1'b0);
		`CHK(q[1:0], 2'h2)
		$display("power down done");
		wrap_up();
	end
endmodule : testbench
